//--- clkpwr_pkg.sv
// Package with register map, field layout and reset values of the clock and power-mode controller.
`default_nettype none
package clkpwr_pkg;
    // Register indexes; the byte address is four times the index.
    localparam logic [18:0] IDX_CLOCK_DIVIDE_CONTROL    = 19'h00004;
    localparam logic [18:0] IDX_PERIPHERAL_BUS_CONFIG   = 19'h0001E;
    localparam logic [18:0] IDX_PLL_DIVIDER_CONTROL_0   = 19'h40020;
    localparam logic [18:0] IDX_PLL_DIVIDER_CONTROL_1   = 19'h40021;
    localparam logic [18:0] IDX_SYSTEM_CLOCK_CONTROL_0  = 19'h40046;
    localparam logic [18:0] IDX_SYSTEM_CLOCK_CONTROL_1  = 19'h40047;
    localparam logic [18:0] IDX_SYSTEM_CLOCK_CONTROL_2  = 19'h4004D;
    localparam logic [18:0] IDX_POWER_STATUS            = 19'h4004E;

    // Divider field positions in clock_divide_control.
    localparam int MAIN_DIV_LSB   = 0;
    localparam int BASE_DIV_LSB   = 2;
    localparam int PERIPH_DIV_LSB = 4;
    // Reset codes: CPU /2, base /6, peripheral /2.
    localparam logic [1:0] MAIN_DIV_RST   = 2'h1;
    localparam logic [1:0] BASE_DIV_RST   = 2'h3;
    localparam logic [1:0] PERIPH_DIV_RST = 2'h0;

    // Clock mode field in system_clock_control_0, bits 1:0.
    typedef enum logic [1:0] {
        MODE_PLL        = 2'h0,
        MODE_MAIN       = 2'h1,
        MODE_LOW_SPEED  = 2'h2,
        MODE_LOW_POWER  = 2'h3
    } clk_mode_t;
    localparam int MODE_LSB       = 0;

    // Field positions in the other control registers.
    localparam int PLL_STOP_BIT   = 0;
    localparam int DRIVE_LSB      = 5;
    localparam int SRC_MAIN_BIT   = 0;
    localparam int FREE_RUN_BIT   = 4;
    localparam int SWALLOW_HI_BIT = 7;
    localparam logic [1:0] DRIVE_RST = 2'h0;

    // Status bits.
    localparam int ST_WAIT_BIT    = 0;
    localparam int ST_STOP_BIT    = 1;
    localparam int ST_REFUSED_BIT = 2;

    // UART channels 7 and 8 cannot wake the device.
    localparam int          UART_CH   = 9;
    localparam logic [8:0]  WAKE_MASK = 9'h07F;

    typedef enum logic [2:0] {
        PS_RUN  = 3'h1,
        PS_WAIT = 3'h2,
        PS_STOP = 3'h4
    } pwr_state_t;
endpackage : clkpwr_pkg
`default_nettype wire

//--- clock_divider_and_power_modes.sv
// Clock divider enables, PLL field registers and low-power mode control behind an APB slave.
//
// Functional notes
// - Reset selects PLL self-oscillation as source.
// - Reset: base /6, CPU and peripheral /2.
// - Main divide field selects 1, 2, 3, 4.
// - Base divide field selects 2, 3, 4, 6.
// - Peripheral divide field selects 2, 3, 4.
// - Refuse stop/wait in PLL high/medium speed.
// - Allow wait from PLL self-oscillation mode.
// - Stop from low-speed; stop/wait from low-power.
// - UART0..6 interrupts wake from wait.
// - UART0..6 wake stop only with external clock.
// - Leaving stop restores the saved CPU ratio.
// - Two-bit oscillator drive select in control 1.
// - Control 1 bit 0 stops the PLL.
// - Main count ratio: bits 2..0 and 6..5.
// - Swallow ratio low bits in bits 4..3.
// - Swallow ratio top bit in bit 7.
// - Reference ratio in PLL control 1 bits 3..0.
// - PLL control 1 bit 4 selects self-oscillation.
`default_nettype none
module clock_divider_and_power_modes #(
    parameter int ADDR_W = 21
) (
    input  wire logic                        clock,
    input  wire logic                        nrst,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [ADDR_W-1:0]           paddr,
    input  wire logic [31:0]                 pwdata,
    output var  logic [31:0]                 prdata,
    output var  logic                        pready,
    output var  logic                        pslverr,
    input  wire logic                        stop_req,
    input  wire logic                        wait_req,
    input  wire logic [clkpwr_pkg::UART_CH-1:0] uart_irq,
    input  wire logic [clkpwr_pkg::UART_CH-1:0] uart_ext_clk,
    output var  logic                        base_tick,
    output var  logic                        cpu_tick,
    output var  logic                        periph_tick,
    output var  logic                        in_wait,
    output var  logic                        in_stop,
    output var  logic                        mode_refused,
    output var  logic                        clk_src_main,
    output var  logic                        pll_osc_stop,
    output var  logic                        pll_free_run_select,
    output var  logic [1:0]                  osc_drive_sel,
    output var  logic [4:0]                  pll_main_count_ratio,
    output var  logic [2:0]                  pll_swallow_count_ratio,
    output var  logic [3:0]                  pll_reference_count_ratio,
    output var  logic [15:0]                 peripheral_bus_config
);
    import clkpwr_pkg::*;

    // ********************************************************
    // Divider helpers
    // ********************************************************
    function automatic logic [2:0] div_next(input logic [2:0] cnt, input logic [2:0] div);
        div_next = (cnt >= div - 3'h1) ? 3'h0 : cnt + 3'h1;
    endfunction : div_next

    function automatic logic [2:0] base_div(input logic [1:0] code);
        base_div = (code == 2'h3) ? 3'h6 : {1'b0, code} + 3'h2;
    endfunction : base_div

    // ********************************************************
    // Registers
    // ********************************************************
    logic [1:0]  main_sel_ff;
    logic [1:0]  base_sel_ff;
    logic [1:0]  periph_sel_ff;
    logic [1:0]  mode_ff;
    logic [1:0]  saved_main_ff;
    logic        refused_sticky_ff;
    pwr_state_t  state_ff;
    pwr_state_t  nxt_state;
    logic [2:0]  base_cnt_ff;
    logic [2:0]  cpu_cnt_ff;
    logic [2:0]  periph_cnt_ff;
    logic [2:0]  base_cur_ff;
    logic [2:0]  cpu_cur_ff;
    logic [2:0]  periph_cur_ff;

    // ********************************************************
    // APB decode
    // ********************************************************
    wire [18:0] idx        = paddr[ADDR_W-1:2];
    wire        aligned    = (paddr[1:0] == 2'h0);
    wire        setup      = psel && !penable;
    wire        wr_commit  = psel && penable && pready && pwrite && !pslverr;
    wire        hit_ccr    = aligned && (idx == IDX_CLOCK_DIVIDE_CONTROL);
    wire        hit_pbc    = aligned && (idx == IDX_PERIPHERAL_BUS_CONFIG);
    wire        hit_pll_divider_control_0   = aligned && (idx == IDX_PLL_DIVIDER_CONTROL_0);
    wire        hit_pll_divider_control_1   = aligned && (idx == IDX_PLL_DIVIDER_CONTROL_1);
    wire        hit_scc0   = aligned && (idx == IDX_SYSTEM_CLOCK_CONTROL_0);
    wire        hit_scc1   = aligned && (idx == IDX_SYSTEM_CLOCK_CONTROL_1);
    wire        hit_scc2   = aligned && (idx == IDX_SYSTEM_CLOCK_CONTROL_2);
    wire        hit_stat   = aligned && (idx == IDX_POWER_STATUS);
    wire        mapped     = hit_ccr || hit_pbc || hit_pll_divider_control_0 || hit_pll_divider_control_1 || hit_scc0 || hit_scc1
                             || hit_scc2 || hit_stat;

    wire [7:0] ccr_val  = {2'h0, periph_sel_ff, base_sel_ff, main_sel_ff};
    wire [7:0] pll_divider_control_0_val = {pll_swallow_count_ratio[2], pll_main_count_ratio[4:3],
                           pll_swallow_count_ratio[1:0], pll_main_count_ratio[2:0]};
    wire [7:0] pll_divider_control_1_val = {3'h0, pll_free_run_select, pll_reference_count_ratio};
    wire [7:0] scc0_val = {6'h0, mode_ff};
    wire [7:0] scc1_val = {1'b0, osc_drive_sel, 4'h0, pll_osc_stop};
    wire [7:0] scc2_val = {7'h0, clk_src_main};
    wire [7:0] stat_val = {5'h0, refused_sticky_ff, in_stop, in_wait};
    logic [31:0] rd_mux;
    always_comb
    begin
        rd_mux = 32'h0;
        if (hit_ccr) rd_mux = {24'h0, ccr_val};
        else if (hit_pbc) rd_mux = {16'h0, peripheral_bus_config};
        else if (hit_pll_divider_control_0) rd_mux = {24'h0, pll_divider_control_0_val};
        else if (hit_pll_divider_control_1) rd_mux = {24'h0, pll_divider_control_1_val};
        else if (hit_scc0) rd_mux = {24'h0, scc0_val};
        else if (hit_scc1) rd_mux = {24'h0, scc1_val};
        else if (hit_scc2) rd_mux = {24'h0, scc2_val};
        else if (hit_stat) rd_mux = {24'h0, stat_val};
    end

    // The answer is prepared in the setup cycle so that the access phase is one cycle long.
    always_ff @(posedge clock)
    begin
        if (!nrst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end else begin
            pready  <= setup;
            pslverr <= setup && !mapped;
            prdata  <= (setup && !pwrite) ? rd_mux : 32'h0;
        end
    end

    // ********************************************************
    // Power-mode control
    // ********************************************************
    wire mode_pll_fast  = (mode_ff == MODE_PLL) && !pll_free_run_select;
    wire mode_pll_self  = (mode_ff == MODE_PLL) && pll_free_run_select;
    wire mode_low_speed = (mode_ff == MODE_LOW_SPEED);
    wire mode_low_power = (mode_ff == MODE_LOW_POWER);
    wire stop_ok        = mode_low_speed || mode_low_power;
    wire wait_ok        = mode_pll_self || mode_low_power;
    wire wake_wait      = |(uart_irq & WAKE_MASK);
    wire wake_stop      = |(uart_irq & uart_ext_clk & WAKE_MASK);
    wire run_now        = (state_ff == PS_RUN);
    wire enter_stop     = run_now && stop_req && stop_ok;
    wire enter_wait     = run_now && !stop_req && wait_req && wait_ok;
    wire refuse_now     = run_now && ((stop_req && !stop_ok) || (!stop_req && wait_req && !wait_ok));
    wire leave_stop     = (state_ff == PS_STOP) && wake_stop;
    wire clr_refused    = wr_commit && hit_stat && pwdata[ST_REFUSED_BIT];

    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            PS_RUN:  if (enter_stop) nxt_state = PS_STOP; else if (enter_wait) nxt_state = PS_WAIT;
            PS_WAIT: if (wake_wait) nxt_state = PS_RUN;
            PS_STOP: if (wake_stop) nxt_state = PS_RUN;
            default: nxt_state = PS_RUN;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (!nrst) begin
            state_ff          <= PS_RUN;
            saved_main_ff     <= MAIN_DIV_RST;
            refused_sticky_ff <= 1'b0;
            mode_refused      <= 1'b0;
            in_wait           <= 1'b0;
            in_stop           <= 1'b0;
        end else begin
            state_ff          <= nxt_state;
            in_wait           <= (nxt_state == PS_WAIT);
            in_stop           <= (nxt_state == PS_STOP);
            mode_refused      <= refuse_now;
            // A refusal in the same cycle as the clear keeps the flag set.
            refused_sticky_ff <= refuse_now || (refused_sticky_ff && !clr_refused);
            if (enter_stop)
                saved_main_ff <= main_sel_ff;
        end
    end

    // ********************************************************
    // Control registers
    // ********************************************************
    always_ff @(posedge clock)
    begin
        if (!nrst) begin
            main_sel_ff               <= MAIN_DIV_RST;
            base_sel_ff               <= BASE_DIV_RST;
            periph_sel_ff             <= PERIPH_DIV_RST;
            mode_ff                   <= MODE_PLL;
            clk_src_main              <= 1'b0;
            pll_free_run_select       <= 1'b1;
            pll_osc_stop              <= 1'b0;
            osc_drive_sel             <= DRIVE_RST;
            pll_main_count_ratio      <= 5'h0;
            pll_swallow_count_ratio   <= 3'h0;
            pll_reference_count_ratio <= 4'h0;
            peripheral_bus_config     <= 16'h0;
        end else begin
            if (leave_stop)
                main_sel_ff <= saved_main_ff;
            else if (wr_commit && hit_ccr)
                main_sel_ff <= pwdata[MAIN_DIV_LSB+:2];
            if (wr_commit && hit_ccr) begin
                base_sel_ff   <= pwdata[BASE_DIV_LSB+:2];
                periph_sel_ff <= pwdata[PERIPH_DIV_LSB+:2];
            end
            if (wr_commit && hit_pbc)
                peripheral_bus_config <= pwdata[15:0];
            if (wr_commit && hit_pll_divider_control_0) begin
                pll_main_count_ratio    <= {pwdata[6:5], pwdata[2:0]};
                pll_swallow_count_ratio <= {pwdata[SWALLOW_HI_BIT], pwdata[4:3]};
            end
            if (wr_commit && hit_pll_divider_control_1) begin
                pll_reference_count_ratio <= pwdata[3:0];
                pll_free_run_select       <= pwdata[FREE_RUN_BIT];
            end
            if (wr_commit && hit_scc0)
                mode_ff <= pwdata[MODE_LSB+:2];
            if (wr_commit && hit_scc1) begin
                pll_osc_stop  <= pwdata[PLL_STOP_BIT];
                osc_drive_sel <= pwdata[DRIVE_LSB+:2];
            end
            if (wr_commit && hit_scc2)
                clk_src_main <= pwdata[SRC_MAIN_BIT];
        end
    end

    // ********************************************************
    // Clock enable dividers
    // ********************************************************
    // New divisors load when a count wraps; the CPU divisor also loads on a base wrap while its count is zero.
    wire src_live    = clk_src_main || !pll_osc_stop;
    wire base_run    = src_live && (state_ff != PS_STOP);
    wire base_wrap   = base_run && (base_cnt_ff >= base_cur_ff - 3'h1);
    wire cpu_wrap    = base_wrap && (state_ff == PS_RUN) && (cpu_cnt_ff >= cpu_cur_ff - 3'h1);
    wire periph_wrap = base_wrap && (periph_cnt_ff >= periph_cur_ff - 3'h1);
    wire [2:0] main_div_w   = {1'b0, main_sel_ff} + 3'h1;
    wire [2:0] periph_div_w = (periph_sel_ff == 2'h3) ? 3'h4 : {1'b0, periph_sel_ff} + 3'h2;

    always_ff @(posedge clock)
    begin
        if (!nrst) begin
            base_cnt_ff   <= 3'h0;
            cpu_cnt_ff    <= 3'h0;
            periph_cnt_ff <= 3'h0;
            base_cur_ff   <= 3'h6;
            cpu_cur_ff    <= 3'h2;
            periph_cur_ff <= 3'h2;
            base_tick     <= 1'b0;
            cpu_tick      <= 1'b0;
            periph_tick   <= 1'b0;
        end else begin
            base_tick   <= base_wrap;
            cpu_tick    <= cpu_wrap;
            periph_tick <= periph_wrap;
            if (base_run)
                base_cnt_ff <= div_next(base_cnt_ff, base_cur_ff);
            if (base_wrap)
                base_cur_ff <= base_div(base_sel_ff);
            if (base_wrap && (state_ff == PS_RUN))
                cpu_cnt_ff <= div_next(cpu_cnt_ff, cpu_cur_ff);
            if (cpu_wrap || (base_wrap && cpu_cnt_ff == 3'h0))
                cpu_cur_ff <= main_div_w;
            if (base_wrap)
                periph_cnt_ff <= div_next(periph_cnt_ff, periph_cur_ff);
            if (periph_wrap)
                periph_cur_ff <= periph_div_w;
        end
    end

    // ********************************************************
    // Checks
    // ********************************************************
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);

    fast_pll_refuse_a: assert property (
        (run_now && mode_pll_fast && (stop_req || wait_req)) |=> (mode_refused && in_stop == 1'b0 && !in_wait))
        else $error("Low-power entry accepted in fast PLL mode.");

    self_osc_wait_a: assert property (
        (run_now && mode_pll_self && wait_req && !stop_req) |=> in_wait)
        else $error("Wait refused in self-oscillation mode.");

    low_mode_stop_a: assert property (
        (run_now && stop_ok && stop_req) |=> (in_stop && !mode_refused && saved_main_ff == $past(main_sel_ff)))
        else $error("Stop refused in a low mode.");

    wait_wake_a: assert property (
        (in_wait && state_ff == PS_WAIT && |(uart_irq[6:0])) |=> !in_wait)
        else $error("Wait not left on a UART interrupt.");

    stop_no_wake_a: assert property (
        (state_ff == PS_STOP && !(|(uart_irq[6:0] & uart_ext_clk[6:0]))) |=> in_stop)
        else $error("Stop left without an externally clocked UART interrupt.");

    ratio_restore_a: assert property (
        leave_stop |=> (!in_stop && main_sel_ff == $past(saved_main_ff)))
        else $error("CPU ratio not restored after stop.");

    stop_quiet_a: assert property (
        (state_ff == PS_STOP) |=> (!cpu_tick && !periph_tick && !base_tick) [*1])
        else $error("Clock enables running in stop.");

    pll_halt_a: assert property (
        (!clk_src_main && pll_osc_stop && $past(!clk_src_main && pll_osc_stop)) |-> !base_tick)
        else $error("Base enable running with PLL stopped.");

    cpu_spacing_a: assert property (
        (cpu_tick && cpu_cur_ff == 3'h2 && base_cur_ff == 3'h6 && $stable(base_sel_ff)
         && $stable(main_sel_ff) && state_ff == PS_RUN && src_live) |=> !cpu_tick [*8])
        else $error("CPU enable faster than base over two.");
endmodule : clock_divider_and_power_modes
`default_nettype wire

//--- clock_divider_and_power_modes_test.sv
// Self-checking testbench of the clock divider and power-mode controller.
`default_nettype none
module clock_divider_and_power_modes_test;
    timeunit 1ns;
    timeprecision 1ns;
    import clkpwr_pkg::*;

    logic        clock = 1'b0;
    logic        nrst = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [20:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic        stop_req = 1'b0;
    logic        wait_req = 1'b0;
    logic [8:0]  uart_irq = '0;
    logic [8:0]  uart_ext_clk = '0;
    logic [31:0] prdata;
    logic        pready, pslverr, base_tick, cpu_tick, periph_tick, in_wait, in_stop, mode_refused;
    logic        clk_src_main, pll_osc_stop, pll_free_run_select;
    logic [1:0]  osc_drive_sel;
    logic [4:0]  pll_main_count_ratio;
    logic [2:0]  pll_swallow_count_ratio;
    logic [3:0]  pll_reference_count_ratio;
    logic [15:0] peripheral_bus_config;
    logic [33:0] expq[$];
    logic [33:0] e;
    int          num_errors = 0;
    int          num_checks = 0;

    clock_divider_and_power_modes dut (
        .clock(clock), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .stop_req(stop_req),
        .wait_req(wait_req), .uart_irq(uart_irq), .uart_ext_clk(uart_ext_clk), .base_tick(base_tick),
        .cpu_tick(cpu_tick), .periph_tick(periph_tick), .in_wait(in_wait), .in_stop(in_stop),
        .mode_refused(mode_refused), .clk_src_main(clk_src_main), .pll_osc_stop(pll_osc_stop),
        .pll_free_run_select(pll_free_run_select), .osc_drive_sel(osc_drive_sel),
        .pll_main_count_ratio(pll_main_count_ratio), .pll_swallow_count_ratio(pll_swallow_count_ratio),
        .pll_reference_count_ratio(pll_reference_count_ratio), .peripheral_bus_config(peripheral_bus_config));

    always #10 clock = ~clock;

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : complete_run

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        num_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[ERR] %0t %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : check

    task automatic give_up(input string msg);
        num_errors++;
        $display("[ERR] %0t no answer from %s", $time, msg);
        complete_run();
    endtask : give_up

    // The expected answer is queued before the request, so the monitor never waits on the driver.
    task automatic apb(input logic wr, input logic [18:0] idx, input logic [31:0] wd, input logic [32:0] exp);
        int n;
        n = 0;
        expq.push_back({wr, exp});
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        do
        begin
            @(posedge clock);
            n++;
            if (n > 20)
                give_up("bus");
        end
        while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [18:0] idx, input logic [31:0] d);
        apb(1'b1, idx, d, 33'h0);
    endtask : wr

    task automatic rd(input logic [18:0] idx, input logic [32:0] exp);
        apb(1'b0, idx, 32'h0, exp);
    endtask : rd

    always @(posedge clock)
        if (psel && penable && pready === 1'b1)
        begin
            e = expq.pop_front();
            check(pslverr, e[32], "bus error flag");
            if (!e[33])
                check(prdata, e[31:0], "read data");
        end

    function automatic logic tick(input int k);
        return k == 0 ? base_tick : (k == 1 ? cpu_tick : periph_tick);
    endfunction : tick

    // Skips whole periods first, since a new divisor only applies from the next wrap.
    task automatic period(input int k, input int skip, output int p);
        int n;
        n = 0;
        p = 0;
        for (int t = 0; t <= skip; t++)
        begin
            p = 0;
            do
            begin
                @(posedge clock);
                n++;
                p++;
                if (n > 400)
                    give_up("tick");
            end
            while (tick(k) !== 1'b1);
        end
    endtask : period

    task automatic pwr(input logic s, input logic w, input logic ew, input logic es, input logic er);
        @(posedge clock);
        stop_req <= s;
        wait_req <= w;
        @(posedge clock);
        stop_req <= 1'b0;
        wait_req <= 1'b0;
        @(negedge clock);
        check(in_wait, ew, "wait state");
        check(in_stop, es, "stop state");
        check(mode_refused, er, "refusal pulse");
    endtask : pwr

    task automatic wake(input logic [8:0] irq, input logic [8:0] ext, input logic ew, input logic es);
        @(posedge clock);
        uart_irq <= irq;
        uart_ext_clk <= ext;
        @(posedge clock);
        @(negedge clock);
        check(in_wait, ew, "wait after interrupt");
        check(in_stop, es, "stop after interrupt");
        @(posedge clock);
        uart_irq <= '0;
    endtask : wake

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        int p;
        int bd[4];
        logic [31:0] v;
        logic [8:0] ch;
        bd = '{2, 3, 4, 6};
        void'($urandom(22));
        repeat (16) @(posedge clock);
        nrst <= 1'b1;
        @(negedge clock);
        check(clk_src_main, 1'b0, "source after reset");
        check(pll_free_run_select, 1'b1, "self-oscillation after reset");
        rd(IDX_CLOCK_DIVIDE_CONTROL, 33'h0D);
        period(0, 1, p);
        check(p, 6, "base period");
        period(1, 1, p);
        check(p, 12, "cpu period");
        period(2, 1, p);
        check(p, 12, "peripheral period");
        $display("test reset done");
        for (int c = 0; c < 4; c++)
        begin
            wr(IDX_CLOCK_DIVIDE_CONTROL, {28'h0, 2'h3, 2'(c)});
            period(1, 3, p);
            check(p, 6 * (c + 1), "cpu divisor");
            wr(IDX_CLOCK_DIVIDE_CONTROL, {28'h0, 2'(c), 2'h0});
            period(0, 3, p);
            check(p, bd[c], "base divisor");
        end
        for (int c = 0; c < 3; c++)
        begin
            wr(IDX_CLOCK_DIVIDE_CONTROL, {26'h0, 2'(c), 4'h4});
            period(2, 3, p);
            check(p, 3 * (c + 2), "peripheral divisor");
        end
        $display("test dividers done");
        v = $urandom;
        wr(IDX_PLL_DIVIDER_CONTROL_0, v);
        rd(IDX_PLL_DIVIDER_CONTROL_0, {25'h0, v[7:0]});
        check(pll_main_count_ratio, {v[6:5], v[2:0]}, "main count");
        check(pll_swallow_count_ratio, {v[7], v[4:3]}, "swallow count");
        wr(IDX_PLL_DIVIDER_CONTROL_1, v);
        @(negedge clock);
        check(pll_reference_count_ratio, v[3:0], "reference count");
        check(pll_free_run_select, v[4], "self-oscillation select");
        wr(IDX_SYSTEM_CLOCK_CONTROL_1, v | 32'h1);
        @(negedge clock);
        check(osc_drive_sel, v[6:5], "drive select");
        check(pll_osc_stop, 1'b1, "oscillator stop");
        // The enable launched on the stopping edge itself may still be high here.
        @(posedge clock);
        p = 0;
        repeat (30) @(posedge clock) p += int'(base_tick);
        check(p, 0, "ticks while oscillator stopped");
        wr(IDX_SYSTEM_CLOCK_CONTROL_1, 32'h0);
        wr(IDX_PERIPHERAL_BUS_CONFIG, v);
        @(negedge clock);
        check(peripheral_bus_config, v[15:0], "bus config");
        rd(19'h00100, {1'b1, 32'h0});
        $display("test registers done");
        wr(IDX_PLL_DIVIDER_CONTROL_1, 32'h10);
        wr(IDX_SYSTEM_CLOCK_CONTROL_0, 32'(MODE_PLL));
        pwr(1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
        wake(9'h080, 9'h1FF, 1'b1, 1'b0);
        wake(9'h100, 9'h1FF, 1'b1, 1'b0);
        ch = 9'h1 << $urandom_range(6, 0);
        wake(ch, 9'h000, 1'b0, 1'b0);
        wr(IDX_PLL_DIVIDER_CONTROL_1, 32'h0);
        pwr(1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
        pwr(1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
        rd(IDX_POWER_STATUS, 33'h04);
        wr(IDX_POWER_STATUS, 32'h4);
        rd(IDX_POWER_STATUS, 33'h00);
        $display("test pll modes done");
        wr(IDX_CLOCK_DIVIDE_CONTROL, 32'h0E);
        wr(IDX_SYSTEM_CLOCK_CONTROL_0, 32'(MODE_LOW_SPEED));
        pwr(1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
        wr(IDX_CLOCK_DIVIDE_CONTROL, 32'h0C);
        wake(ch, 9'h000, 1'b0, 1'b1);
        wake(9'h180, 9'h1FF, 1'b0, 1'b1);
        wake(ch, ch, 1'b0, 1'b0);
        rd(IDX_CLOCK_DIVIDE_CONTROL, 33'h0E);
        period(1, 3, p);
        check(p, 18, "cpu period after stop");
        wr(IDX_SYSTEM_CLOCK_CONTROL_0, 32'(MODE_LOW_POWER));
        pwr(1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
        wake(9'h002, 9'h000, 1'b0, 1'b0);
        pwr(1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
        wake(9'h004, 9'h004, 1'b0, 1'b0);
        $display("test low power done");
        complete_run();
    end
endmodule : clock_divider_and_power_modes_test
`default_nettype wire
